// ==== rtl/vdc_regs.sv ====
`timescale 1ns/1ps
`default_nettype none

module vdc_regs #(
   parameter logic [vdc_pkg::MG_ADDR_W-1:0] EE_LAST_ADDR = 6'h3F,
   // Expected self-test signature, value arbitrary
   parameter logic [31:0]                   SIG_EXPECT   = 32'h5A5A_0001
) (
   // Clock and reset
   input  wire logic                        i_clk,
   input  wire logic                        i_resetn,
   // Decoded register access from the programming link
   input  wire vdc_pkg::vdc_reg_req_t       i_reg,
   output logic [31:0]                      o_reg_rdata,
   output logic                             o_reg_rvalid,
   // Margin check port of the memory array
   output vdc_pkg::vdc_ee_req_t             o_ee_req,
   input  wire logic                        i_ee_done,
   input  wire logic                        i_ee_fail,
   // Logic self-test
   input  wire logic                        i_bist_done,
   input  wire logic [31:0]                 i_bist_sig,
   // Access code recognised by the link
   input  wire logic                        i_access_ok,
   // Diagnostics
   input  wire logic [vdc_pkg::DIAG_W-1:0]  i_diag_raw,
   input  wire logic [vdc_pkg::DIAG_W-1:0]  i_diag_mask,
   input  wire logic [vdc_pkg::RADIUS_W-1:0] i_radius_lo,
   input  wire logic [vdc_pkg::RADIUS_W-1:0] i_radius_hi,
   // Signal path snapshots
   input  wire logic [15:0]                 i_temp,
   input  wire logic [15:0]                 i_angle,
   input  wire logic [15:0]                 i_chan_b,
   input  wire logic [15:0]                 i_chan_a,
   input  wire logic [15:0]                 i_chan_b_pre,
   input  wire logic [15:0]                 i_chan_a_pre,
   input  wire logic [vdc_pkg::RADIUS_W-1:0] i_radius_sq,
   // Output stage control
   output logic                             o_output_hiz,
   output logic                             o_link_active,
   output logic                             o_logic_fault
);

   // Assertion clock and reset
   default clocking asrt_cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);

   // Margin register fields and sequencer state
   logic                          go_q;
   logic                          up_skip_q;
   logic                          lo_skip_q;
   vdc_pkg::vdc_mstat_t           mstat_q;
   logic                          side_q;
   logic                          addr_en_q;
   logic [vdc_pkg::MG_ADDR_W-1:0] chk_addr_q;
   logic                          repeat_q;
   vdc_pkg::vdc_seq_t             seq_q;
   logic [vdc_pkg::MG_ADDR_W-1:0] cur_q;
   logic                          cur_upper_q;
   logic                          any_fail_q;
   logic                          req_q;

   // Other register state
   logic                          st_done_q;
   logic                          st_pass_q;
   logic [31:0]                   sig_q;
   logic                          unlock_q;
   logic                          force_q;
   logic [vdc_pkg::DIAG_W-1:0]    diag_q;
   logic [31:0]                   angtemp_q;
   logic [31:0]                   chfinal_q;
   logic [31:0]                   chpre_q;
   logic [vdc_pkg::RADIUS_W-1:0]  radius_q;

   // Decode helpers
   logic                          wr_margin;
   logic                          first_upper;
   logic                          last_side;
   logic [vdc_pkg::DIAG_W-1:0]    diag_cond;
   logic                          radius_bad;

   assign wr_margin   = i_reg.wr && (i_reg.addr == vdc_pkg::ADDR_MARGIN);
   assign first_upper = lo_skip_q;
   assign last_side   = cur_upper_q || up_skip_q;

   // Margin control register and check sequencer
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         go_q        <= 1'b0;
         up_skip_q   <= 1'b0;
         lo_skip_q   <= 1'b0;
         mstat_q     <= vdc_pkg::VDC_MS_NOTRUN;
         side_q      <= 1'b0;
         addr_en_q   <= 1'b0;
         chk_addr_q  <= vdc_pkg::MG_ADDR_RST;
         repeat_q    <= 1'b0;
         seq_q       <= vdc_pkg::VDC_SQ_IDLE;
         cur_q       <= vdc_pkg::MG_ADDR_RST;
         cur_upper_q <= 1'b0;
         any_fail_q  <= 1'b0;
         req_q       <= 1'b0;
      end else begin
         case (seq_q)
            vdc_pkg::VDC_SQ_IDLE: begin
               if (wr_margin) begin
                  up_skip_q  <= i_reg.wdata[vdc_pkg::MG_UPSKIP_BIT];
                  lo_skip_q  <= i_reg.wdata[vdc_pkg::MG_LOSKIP_BIT];
                  addr_en_q  <= i_reg.wdata[vdc_pkg::MG_ADDREN_BIT];
                  chk_addr_q <= i_reg.wdata[vdc_pkg::MG_ADDR_LSB +:
                                            vdc_pkg::MG_ADDR_W];
                  repeat_q   <= i_reg.wdata[vdc_pkg::MG_REPEAT_BIT];
                  if (i_reg.wdata[vdc_pkg::MG_GO_BIT]) begin
                     any_fail_q <= 1'b0;
                     // Custom or zero start address
                     if (i_reg.wdata[vdc_pkg::MG_ADDREN_BIT]) begin
                        cur_q <= i_reg.wdata[vdc_pkg::MG_ADDR_LSB +:
                                             vdc_pkg::MG_ADDR_W];
                     end else begin
                        cur_q <= vdc_pkg::MG_ADDR_RST;
                     end
                     cur_upper_q <= i_reg.wdata[vdc_pkg::MG_LOSKIP_BIT];
                     if (i_reg.wdata[vdc_pkg::MG_LOSKIP_BIT] &&
                         i_reg.wdata[vdc_pkg::MG_UPSKIP_BIT]) begin
                        // Nothing to check: passes at once
                        mstat_q <= vdc_pkg::VDC_MS_PASS;
                     end else begin
                        go_q    <= 1'b1;
                        req_q   <= 1'b1;
                        mstat_q <= vdc_pkg::VDC_MS_RUN;
                        seq_q   <= vdc_pkg::VDC_SQ_CHECK;
                     end
                  end
               end
            end
            vdc_pkg::VDC_SQ_CHECK: begin
               if (i_ee_done) begin
                  req_q <= 1'b0;
                  seq_q <= vdc_pkg::VDC_SQ_NEXT;
                  if (i_ee_fail) begin
                     any_fail_q <= 1'b1;
                     side_q     <= cur_upper_q;
                     chk_addr_q <= cur_q;
                  end
               end
            end
            vdc_pkg::VDC_SQ_NEXT: begin
               if (!last_side) begin
                  cur_upper_q <= 1'b1;
                  req_q       <= 1'b1;
                  seq_q       <= vdc_pkg::VDC_SQ_CHECK;
               end else if (repeat_q) begin
                  cur_upper_q <= first_upper;
                  req_q       <= 1'b1;
                  seq_q       <= vdc_pkg::VDC_SQ_CHECK;
               end else if (cur_q == EE_LAST_ADDR) begin
                  go_q  <= 1'b0;
                  seq_q <= vdc_pkg::VDC_SQ_IDLE;
                  if (any_fail_q) begin
                     mstat_q <= vdc_pkg::VDC_MS_FAIL;
                  end else begin
                     mstat_q <= vdc_pkg::VDC_MS_PASS;
                  end
               end else begin
                  cur_q       <= cur_q + 6'h01;
                  cur_upper_q <= first_upper;
                  req_q       <= 1'b1;
                  seq_q       <= vdc_pkg::VDC_SQ_CHECK;
               end
            end
            default: begin
               seq_q <= vdc_pkg::VDC_SQ_IDLE;
               req_q <= 1'b0;
            end
         endcase
         // Early stop by clearing go, wins over sequencing
         if (wr_margin && (seq_q != vdc_pkg::VDC_SQ_IDLE) &&
             !i_reg.wdata[vdc_pkg::MG_GO_BIT]) begin
            go_q  <= 1'b0;
            req_q <= 1'b0;
            seq_q <= vdc_pkg::VDC_SQ_IDLE;
            if (any_fail_q ||
                ((seq_q == vdc_pkg::VDC_SQ_CHECK) && i_ee_done &&
                 i_ee_fail)) begin
               mstat_q <= vdc_pkg::VDC_MS_FAIL;
            end else begin
               mstat_q <= vdc_pkg::VDC_MS_NOTRUN;
            end
         end
      end
   end

   // Check request drive
   assign o_ee_req = '{req:   req_q,
                       addr:  cur_q,
                       upper: cur_upper_q};

   // Self-test capture and signature compare
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_done_q     <= 1'b0;
         st_pass_q     <= 1'b0;
         sig_q         <= vdc_pkg::WORD_RST;
         o_logic_fault <= 1'b0;
      end else if (i_bist_done && !st_done_q) begin
         st_done_q     <= 1'b1;
         sig_q         <= i_bist_sig;
         st_pass_q     <= (i_bist_sig == SIG_EXPECT);
         o_logic_fault <= (i_bist_sig != SIG_EXPECT);
      end
   end

   // Sticky unlock after a valid access code
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         unlock_q <= 1'b0;
      end else if (i_access_ok) begin
         unlock_q <= 1'b1;
      end
   end

   // Force programming interface bit and output stage
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         force_q       <= vdc_pkg::FORCE_RST;
         o_output_hiz  <= vdc_pkg::FORCE_RST;
         o_link_active <= vdc_pkg::FORCE_RST;
      end else if (i_reg.wr && (i_reg.addr == vdc_pkg::ADDR_FORCE)) begin
         force_q       <= i_reg.wdata[vdc_pkg::FORCE_BIT];
         o_output_hiz  <= i_reg.wdata[vdc_pkg::FORCE_BIT];
         o_link_active <= i_reg.wdata[vdc_pkg::FORCE_BIT];
      end
   end

   // Radius range check and masked diagnostic flags
   assign radius_bad = (radius_q < i_radius_lo) ||
                       (radius_q > i_radius_hi);
   always_comb begin
      diag_cond                   = i_diag_raw;
      diag_cond[vdc_pkg::SRR_BIT] = radius_bad;
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         diag_q <= '0;
      end else begin
         diag_q <= diag_cond & ~i_diag_mask;
      end
   end

   // Signal path snapshots
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         angtemp_q <= vdc_pkg::WORD_RST;
         chfinal_q <= vdc_pkg::WORD_RST;
         chpre_q   <= vdc_pkg::WORD_RST;
         radius_q  <= '0;
      end else begin
         angtemp_q <= {i_temp, i_angle};
         chfinal_q <= {i_chan_b, i_chan_a};
         chpre_q   <= {i_chan_b_pre, i_chan_a_pre};
         radius_q  <= i_radius_sq;
      end
   end

   // Read mux; unmapped addresses give no answer
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_reg_rdata  <= vdc_pkg::WORD_RST;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rvalid <= 1'b0;
         if (i_reg.rd) begin
            o_reg_rvalid <= 1'b1;
            o_reg_rdata  <= vdc_pkg::WORD_RST;
            case (i_reg.addr)
               vdc_pkg::ADDR_MARGIN: begin
                  o_reg_rdata[vdc_pkg::MG_GO_BIT]     <= go_q;
                  o_reg_rdata[vdc_pkg::MG_UPSKIP_BIT] <= up_skip_q;
                  o_reg_rdata[vdc_pkg::MG_LOSKIP_BIT] <= lo_skip_q;
                  o_reg_rdata[vdc_pkg::MG_STATE_LSB +: 2] <= mstat_q;
                  o_reg_rdata[vdc_pkg::MG_SIDE_BIT]   <= side_q;
                  o_reg_rdata[vdc_pkg::MG_ADDREN_BIT] <= addr_en_q;
                  o_reg_rdata[vdc_pkg::MG_ADDR_LSB +: vdc_pkg::MG_ADDR_W]
                     <= chk_addr_q;
                  o_reg_rdata[vdc_pkg::MG_REPEAT_BIT] <= repeat_q;
               end
               vdc_pkg::ADDR_SELFTEST: begin
                  o_reg_rdata[vdc_pkg::ST_DONE_BIT] <= st_done_q;
                  o_reg_rdata[vdc_pkg::ST_PASS_BIT] <= st_pass_q;
               end
               vdc_pkg::ADDR_UNLOCK: begin
                  o_reg_rdata[vdc_pkg::UNLOCK_BIT] <= unlock_q;
               end
               vdc_pkg::ADDR_FORCE: begin
                  o_reg_rdata[vdc_pkg::FORCE_BIT] <= force_q;
               end
               vdc_pkg::ADDR_SIGN: begin
                  o_reg_rdata <= sig_q;
               end
               vdc_pkg::ADDR_DIAG: begin
                  o_reg_rdata[vdc_pkg::DIAG_W-1:0] <= diag_q;
               end
               vdc_pkg::ADDR_ANGTEMP: begin
                  o_reg_rdata <= angtemp_q;
               end
               vdc_pkg::ADDR_CHFINAL: begin
                  o_reg_rdata <= chfinal_q;
               end
               vdc_pkg::ADDR_CHPRE: begin
                  o_reg_rdata <= chpre_q;
               end
               vdc_pkg::ADDR_RADIUS: begin
                  o_reg_rdata[vdc_pkg::RADIUS_W-1:0] <= radius_q;
               end
               default: begin
                  o_reg_rvalid <= 1'b0;
               end
            endcase
         end
      end
   end

   // Start address follows the enable bit
   zero_start_a: assert property (
      (wr_margin && seq_q == vdc_pkg::VDC_SQ_IDLE && i_reg.wdata[0] &&
       !i_reg.wdata[6] && !(i_reg.wdata[1] && i_reg.wdata[2]))
      |=> (o_ee_req.req && o_ee_req.addr == 6'h00))
      else $error("margin run did not start at zero");

   custom_start_a: assert property (
      (wr_margin && seq_q == vdc_pkg::VDC_SQ_IDLE && i_reg.wdata[0] &&
       i_reg.wdata[6] && !(i_reg.wdata[1] && i_reg.wdata[2]))
      |=> (o_ee_req.req && o_ee_req.addr == $past(i_reg.wdata[12:7])))
      else $error("margin run did not start at custom address");

   fail_side_a: assert property (
      (o_ee_req.req && i_ee_done && i_ee_fail)
      |=> (side_q == $past(o_ee_req.upper)) && (chk_addr_q == $past(cur_q)))
      else $error("fail side or address not recorded");

   run_status_a: assert property (
      (seq_q != vdc_pkg::VDC_SQ_IDLE) |-> (mstat_q == vdc_pkg::VDC_MS_RUN))
      else $error("status not running during sequence");

   lower_skip_a: assert property (
      (o_ee_req.req && lo_skip_q) |-> o_ee_req.upper)
      else $error("lower check issued while skipped");

   upper_skip_a: assert property (
      (o_ee_req.req && up_skip_q) |-> !o_ee_req.upper)
      else $error("upper check issued while skipped");

   go_clear_a: assert property (
      $fell(go_q) |-> (mstat_q != vdc_pkg::VDC_MS_RUN) &&
                      (seq_q == vdc_pkg::VDC_SQ_IDLE))
      else $error("go cleared without final status");

   abort_run_a: assert property (
      (wr_margin && seq_q != vdc_pkg::VDC_SQ_IDLE && !i_reg.wdata[0])
      |=> (!go_q && !o_ee_req.req ##1 !o_ee_req.req))
      else $error("margin run not stopped early");

   selftest_pass_a: assert property (
      st_pass_q |-> st_done_q)
      else $error("self-test pass shown before done");

   unlock_set_a: assert property (
      i_access_ok |=> unlock_q)
      else $error("unlock bit not set");

   force_hiz_a: assert property (
      (i_reg.wr && i_reg.addr == vdc_pkg::ADDR_FORCE)
      |=> (o_output_hiz == $past(i_reg.wdata[7])) &&
          (o_link_active == o_output_hiz))
      else $error("output stage not following force bit");

   diag_mask_a: assert property (
      1'b1 |=> ((diag_q & $past(i_diag_mask)) == '0))
      else $error("masked diagnostic flag visible");

endmodule

`default_nettype wire

// ==== shared/vdc_pkg.sv ====
`default_nettype none

package vdc_pkg;

   // Register offsets on the programming link
   localparam logic [7:0] ADDR_MARGIN   = 8'h83;
   localparam logic [7:0] ADDR_SELFTEST = 8'h85;
   localparam logic [7:0] ADDR_UNLOCK   = 8'h86;
   localparam logic [7:0] ADDR_FORCE    = 8'hA0;
   localparam logic [7:0] ADDR_SIGN     = 8'hA1;
   localparam logic [7:0] ADDR_DIAG     = 8'hA3;
   localparam logic [7:0] ADDR_ANGTEMP  = 8'hA7;
   localparam logic [7:0] ADDR_CHFINAL  = 8'hA8;
   localparam logic [7:0] ADDR_CHPRE    = 8'hA9;
   localparam logic [7:0] ADDR_RADIUS   = 8'hAA;

   // Margin test control field positions
   localparam int MG_GO_BIT     = 0;
   localparam int MG_UPSKIP_BIT = 1;
   localparam int MG_LOSKIP_BIT = 2;
   localparam int MG_STATE_LSB  = 3;
   localparam int MG_SIDE_BIT   = 5;
   localparam int MG_ADDREN_BIT = 6;
   localparam int MG_ADDR_LSB   = 7;
   localparam int MG_REPEAT_BIT = 13;
   localparam int MG_ADDR_W     = 6;

   // Other field positions
   localparam int ST_DONE_BIT   = 4;
   localparam int ST_PASS_BIT   = 5;
   localparam int UNLOCK_BIT    = 1;
   localparam int FORCE_BIT     = 7;
   localparam int DIAG_W        = 13;
   localparam int RADIUS_W      = 17;
   localparam int SRR_BIT       = 5;

   // Reset values
   localparam logic [MG_ADDR_W-1:0] MG_ADDR_RST  = 6'h00;
   localparam logic                 FORCE_RST    = 1'b0;
   localparam logic [31:0]          WORD_RST     = 32'h0000_0000;

   // Margin test status codes
   typedef enum logic [1:0] {
      VDC_MS_NOTRUN = 2'b00,
      VDC_MS_PASS   = 2'b01,
      VDC_MS_FAIL   = 2'b10,
      VDC_MS_RUN    = 2'b11
   } vdc_mstat_t;

   // Margin sequencer states
   typedef enum logic [1:0] {
      VDC_SQ_IDLE  = 2'b00,
      VDC_SQ_CHECK = 2'b01,
      VDC_SQ_NEXT  = 2'b10
   } vdc_seq_t;

   // One margin check request towards the memory array
   typedef struct packed {
      logic                 req;
      logic [MG_ADDR_W-1:0] addr;
      logic                 upper;
   } vdc_ee_req_t;

   // One decoded register transaction from the link
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } vdc_reg_req_t;

endpackage

`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [31:0] SIG = 32'h1234_5678; // Arbitrary value
   vdc_pkg::vdc_reg_req_t reg_q;
   vdc_pkg::vdc_ee_req_t  ee_req;
   logic [31:0]           rdata, rd_v, bsig;
   logic [16:0]           rsq;
   logic [15:0]           snap;
   logic [12:0]           draw, dmask;
   logic [5:0]            fail_addr;
   logic [4:0]            wait_c;
   logic                  i_clk, i_resetn, rvalid, done, fail, bist_done;
   logic                  acc_ok, hiz, link, fault, fail_up, fail_en, prev;
   int                    n_errors, comparisons, n_lo, n_up, cyc;

   vdc_regs #(.EE_LAST_ADDR(6'h03), .SIG_EXPECT(SIG)) DUT (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_reg(reg_q),
      .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_ee_req(ee_req),
      .i_ee_done(done), .i_ee_fail(fail), .i_bist_done(bist_done),
      .i_bist_sig(bsig), .i_access_ok(acc_ok), .i_diag_raw(draw),
      .i_diag_mask(dmask), .i_radius_lo(17'h0_0064),
      .i_radius_hi(17'h0_00C8), .i_temp(snap), .i_angle(~snap),
      .i_chan_b(snap ^ 16'h00FF), .i_chan_a(snap + 16'h0001),
      .i_chan_b_pre(snap - 16'h0001),
      .i_chan_a_pre({snap[7:0], snap[15:8]}), .i_radius_sq(rsq),
      .o_output_hiz(hiz), .o_link_active(link), .o_logic_fault(fault));
   vdc_ee_model ARRAY (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_req(ee_req),
      .i_fail_addr(fail_addr), .i_fail_up(fail_up), .i_fail_en(fail_en),
      .i_wait(wait_c), .o_done(done), .o_fail(fail));

   // Clock
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   // Counts check requests per side, cuts a hang short
   always @(posedge i_clk) begin
      prev <= ee_req.req;
      if (ee_req.req === 1'b1 && !prev && ee_req.upper) n_up <= n_up + 1;
      if (ee_req.req === 1'b1 && !prev && !ee_req.upper) n_lo <= n_lo + 1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         complete_run();
      end
   end

   task automatic complete_run();
      if (n_errors == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      reg_q <= '{1'b1, 1'b0, a, d};
      @(posedge i_clk);
      reg_q <= '0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge i_clk);
      reg_q <= '{1'b0, 1'b1, a, 32'h0000_0000};
      @(posedge i_clk);
      reg_q <= '0;
      rd_v = 'x;
      repeat (3) begin
         #1;
         if (rvalid === 1'b1) rd_v = rdata;
         @(posedge i_clk);
      end
   endtask
   task automatic await_req(input logic lvl);
      #1;
      for (int i = 0; i < 40 && ee_req.req !== lvl; i++) begin
         @(posedge i_clk);
         #1;
      end
   endtask
   task automatic finish_run();
      rd_v = 32'h0000_0001;
      for (int i = 0; i < 40 && rd_v[0] !== 1'b0; i++) rd(8'h83);
   endtask
   task automatic do_reset();
      i_resetn <= 1'b0;
      repeat (10) @(posedge i_clk);
      i_resetn <= 1'b1;
   endtask

   task automatic t_idle();
      rd(8'h83);
      chk("margin", rd_v, 32'h0000_0000);
      rd(8'h84);
      chk("unmapped", rd_v, 'x);
      wr(8'hA1, 32'hFFFF_FFFF);
      rd(8'hA1);
      chk("sig", rd_v, 32'h0000_0000);
      rd(8'h85);
      chk("st done", rd_v[4], 1'b0);
   endtask
   task automatic t_pass(input logic [31:0] w, input int lo, up);
      int b_lo, b_up;
      b_lo = n_lo;
      b_up = n_up;
      wr(8'h83, w);
      await_req(1'b1);
      chk("start", ee_req.addr, 6'h00);
      finish_run();
      chk("pass", rd_v[5:0], {3'b001, w[2:1], 1'b0});
      chk("n lower", n_lo - b_lo, lo);
      chk("n upper", n_up - b_up, up);
   endtask
   task automatic t_fail(input logic [31:0] w, input logic [5:0] a, s,
                         input logic up, input logic [13:0] exp);
      fail_addr <= a;
      fail_up <= up;
      fail_en <= 1'b1;
      wr(8'h83, w);
      await_req(1'b1);
      chk("start", ee_req.addr, s);
      finish_run();
      chk("fail", rd_v[13:0], exp);
      fail_en <= 1'b0;
   endtask
   task automatic t_abort();
      wait_c <= 5'h14;
      wr(8'h83, 32'h0000_0001);
      rd(8'h83);
      chk("run", rd_v[4:0], 5'b11001);
      wr(8'h83, 32'h0000_0000);
      rd(8'h83);
      chk("abort", {rd_v[4:0], ee_req.req}, 6'h00);
      wait_c <= 5'h00;
   endtask
   task automatic t_repeat();
      wr(8'h83, 32'h0000_2141);
      repeat (4) begin
         await_req(1'b1);
         chk("repeat", ee_req.addr, 6'h02);
         await_req(1'b0);
      end
      wr(8'h83, 32'h0000_0000);
      finish_run();
   endtask
   task automatic t_selftest(input logic [31:0] s, input logic ok);
      bsig <= s;
      bist_done <= 1'b1;
      @(posedge i_clk);
      bist_done <= 1'b0;
      rd(8'h85);
      chk("st", rd_v[5:4], {ok, 1'b1});
      rd(8'hA1);
      chk("sig", {rd_v, fault}, {s, !ok});
   endtask
   task automatic t_unlock_force();
      rd(8'h86);
      chk("lock", {rd_v[1], hiz, link}, 3'b000);
      acc_ok <= 1'b1;
      @(posedge i_clk);
      acc_ok <= 1'b0;
      wr(8'hA0, 32'h0000_0080);
      rd(8'h86);
      chk("unlock", rd_v[1], 1'b1);
      rd(8'hA0);
      chk("force", {rd_v[7], hiz, link}, 3'b111);
   endtask
   task automatic t_diag_snap();
      draw <= 13'h1FFF;
      dmask <= 13'h0A5A;
      rsq <= 17'h0_012C;
      snap <= 16'hFF80;
      // Radius passes a snapshot and the flag register before reading
      @(posedge i_clk);
      rd(8'hA3);
      chk("diag", rd_v, 32'h0000_15A5);
      rsq <= 17'h0_0096;
      @(posedge i_clk);
      rd(8'hA3);
      chk("diag", rd_v, 32'h0000_1585);
      rd(8'hA7);
      chk("angtemp", rd_v, {snap, ~snap});
      rd(8'hA8);
      chk("final", rd_v, {snap ^ 16'h00FF, snap + 16'h0001});
      rd(8'hA9);
      chk("pre", rd_v, {snap - 16'h0001, snap[7:0], snap[15:8]});
      rd(8'hAA);
      chk("radius", rd_v, {15'h0000, rsq});
   endtask

   // Main sequence
   initial begin
      {reg_q, bist_done, acc_ok, fail_en, fail_up, prev, bsig} = '0;
      {draw, dmask, rsq, snap, fail_addr, wait_c} = '0;
      i_resetn = 1'b0;
      do_reset();
      t_idle();
      t_pass(32'h0000_0001, 4, 4);
      t_pass(32'h0000_0005, 0, 4);
      t_fail(32'h0000_0141, 6'h03, 6'h02, 1'b1, 14'h01F0);
      t_fail(32'h0000_0003, 6'h01, 6'h00, 1'b0, 14'h0192);
      t_abort();
      t_repeat();
      t_selftest(SIG, 1'b1);
      t_unlock_force();
      t_diag_snap();
      do_reset();
      t_idle();
      t_selftest(~SIG, 1'b0);
      complete_run();
   end
endmodule
`default_nettype wire

// ==== verif/vdc_ee_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module vdc_ee_model (
   // Clock, reset and check request
   input  wire logic                 i_clk,
   input  wire logic                 i_resetn,
   input  wire vdc_pkg::vdc_ee_req_t i_req,
   // Fault injection and answer delay
   input  wire logic [5:0]           i_fail_addr,
   input  wire logic                 i_fail_up,
   input  wire logic                 i_fail_en,
   input  wire logic [4:0]           i_wait,
   // Answer
   output logic                      o_done,
   output logic                      o_fail
);
   logic [4:0] cnt_q;
   logic       busy;

   // Open check not yet answered
   assign busy = i_req.req && !o_done;

   // One answer per check; fail line toggles outside answers
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt_q  <= '0;
         o_done <= 1'b0;
         o_fail <= 1'b0;
      end else begin
         cnt_q  <= (busy && cnt_q != i_wait) ? cnt_q + 5'h01 : 5'h00;
         o_done <= busy && cnt_q == i_wait;
         o_fail <= (busy && cnt_q == i_wait) ? i_fail_en &&
                   i_req.upper == i_fail_up && i_req.addr >= i_fail_addr
                   : ~o_fail;
      end
   end
endmodule
`default_nettype wire
